// File: bench/pmcap_props.sv
// Assertion checker for the power management capability registers.
`timescale 1ns/1ps
module pmcap_props (
	// Clock, reset, state and read channels.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic func_reset,
	input wire logic [1:0] power_state,
	input wire logic pme_enable,
	input wire logic pme_active,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [pmcap_pkg::ADDR_W-1:0] araddr,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	import pmcap_pkg::*;
	logic take, hdr, csr;
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	assign take = arvalid && arready;
	assign hdr = take && araddr == HDR_OFFSET;
	assign csr = take && araddr == CSR_OFFSET;
	chk_read_answer: assert property (take |=> rvalid) else $error("read late");
	chk_head_fixed: assert property (hdr |=> rdata[26:25] == 2'h0 && rdata[20:19] == 2'h1)
		else $error("header fixed bits");
	chk_csr_rsvd: assert property (csr |=> rdata[23:16] == 8'h0 && rdata[7:4] == 4'h0 && !rdata[2])
		else $error("reserved bits set");
	chk_csr_live: assert property (csr |=> rdata[8] == $past(pme_enable) &&
		rdata[1:0] == $past(power_state)) else $error("state mirror");
	chk_state_legal: assert property (power_state != PS_D1 && power_state != PS_D2)
		else $error("illegal state");
	chk_pme_gate: assert property (!pme_enable |=> !pme_active) else $error("pme gate");
	chk_func_reset: assert property (func_reset |=> power_state == PS_D0) else $error("rst");
	chk_unmapped_read: assert property (take && !hdr && !csr |=> rresp == RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read");
	cover property (csr);
	cover property (pme_active);
	cover property (func_reset);
endmodule
bind pmcap_regs pmcap_props pmcap_props_i (
	.aclk(aclk), .aresetn(aresetn), .func_reset(func_reset), .power_state(power_state),
	.pme_enable(pme_enable), .pme_active(pme_active), .arvalid(arvalid), .arready(arready),
	.araddr(araddr), .rvalid(rvalid), .rdata(rdata), .rresp(rresp)
);

// File: bench/tb_pmcap_regs.sv
// Self-checking testbench for the power management capability registers.
`timescale 1ns/1ps
module tb_pmcap_regs;
	import pmcap_pkg::*;
	localparam logic [31:0] HDR_EXP = {PME_SUP_RST, 2'h0, AUX_RST, DSI_RST, 1'h0, 1'h1,
		VERSION_RST, NEXT_PTR_RST, CAP_ID_RST};
	logic aclk = 1'h0, aresetn = 1'h0, func_reset = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
	logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0, ee_wr = 1'h0, pme_event = 1'h0;
	logic eeprom_present = 1'h0, hw_autocfg = 1'h0, awready, wready, bvalid, arready, rvalid;
	logic pme_enable, pme_active;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0, ee_addr = 8'h0;
	logic [31:0] wdata = 32'h0, ee_data = 32'h0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic [2:0] awprot = 3'h0, arprot = 3'h0;
	logic [1:0] bresp, rresp, power_state;
	int error_cnt = 0, n_checks = 0, cyc = 0;
	always #20 aclk = ~aclk;
	pmcap_regs pmcap_regs_i (
		.aclk(aclk), .aresetn(aresetn), .func_reset(func_reset),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.ee_wr(ee_wr), .ee_addr(ee_addr), .ee_data(ee_data),
		.eeprom_present(eeprom_present), .hw_autocfg(hw_autocfg), .pme_event(pme_event),
		.power_state(power_state), .pme_enable(pme_enable), .pme_active(pme_active)
	);
	task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(logic [31:0] d, logic [1:0] er = RESP_OKAY, logic [7:0] a = CSR_OFFSET);
		logic done;
		done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
			if (bvalid && bready) begin
				bready <= 1'h0;
				done = 1'b1;
				cmp("bresp", {30'h0, er}, {30'h0, bresp});
			end
		end
		@(posedge aclk);
	endtask
	task automatic rd(logic [31:0] e, logic [1:0] er = RESP_OKAY, logic [7:0] a = CSR_OFFSET);
		logic done;
		done = 1'b0;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
			if (rvalid && rready) begin
				rready <= 1'h0;
				done = 1'b1;
				cmp("rresp", {30'h0, er}, {30'h0, rresp});
				cmp("rdata", e, rdata);
			end
		end
		@(posedge aclk);
	endtask
	task automatic ee(logic [31:0] d, logic [7:0] a = CSR_OFFSET);
		ee_addr <= a;
		ee_data <= d;
		ee_wr <= 1'h1;
		@(posedge aclk);
		ee_wr <= 1'h0;
	endtask
	task automatic pme_hit;
		pme_event <= 1'h1;
		@(posedge aclk);
		pme_event <= 1'h0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic t_map;
		rd(HDR_EXP, RESP_OKAY, HDR_OFFSET);
		wr(32'hffffffff, RESP_OKAY, HDR_OFFSET);
		rd(HDR_EXP, RESP_OKAY, HDR_OFFSET);
		ee(32'hffffffff, HDR_OFFSET);
		rd(32'hf9efffff, RESP_OKAY, HDR_OFFSET);
		ee(HDR_EXP, HDR_OFFSET);
		rd(HDR_EXP, RESP_OKAY, HDR_OFFSET);
		rd(32'h8);
		wr(32'h0, RESP_SLVERR, 8'h48);
		rd(32'h0, RESP_SLVERR, 8'h48);
	endtask
	task automatic t_ps;
		logic [1:0] cur;
		cur = PS_D0;
		for (int i = 3; i >= 0; i--) begin
			wr(32'(i));
			if (i == 3 || i == 0) cur = 2'(i);
			rd({28'h0, 2'h2, cur});
			cmp("power_state", {30'h0, cur}, {30'h0, power_state});
		end
	endtask
	task automatic t_pme;
		wr(32'h103);
		pme_hit;
		cmp("pme_active", 32'h1, {31'h0, pme_active});
		rd(32'h810b);
		pme_event <= 1'h1;
		wr(32'h8103);
		pme_event <= 1'h0;
		rd(32'h810b);
		wr(32'h8103);
		rd(32'h10b);
		cmp("pme_active", 32'h0, {31'h0, pme_active});
		func_reset <= 1'h1;
		@(posedge aclk);
		func_reset <= 1'h0;
		rd(32'h108);
		cmp("pme_enable", 32'h1, {31'h0, pme_enable});
		wr(32'h0);
		pme_hit;
		rd(32'h8);
	endtask
	task automatic t_dsel;
		wr(32'h600);
		rd(32'h8);
		ee(32'h77002008);
		rd(32'h8);
		eeprom_present <= 1'h1;
		repeat (3) @(posedge aclk);
		rd(32'h77002008);
		ee(32'h5a004608);
		rd(32'h5a004608);
		wr(32'h0);
		rd(32'h77002008);
		wr(32'h800);
		rd(32'h808);
	endtask
	task automatic t_auto;
		hw_autocfg <= 1'h1;
		repeat (3) @(posedge aclk);
		wr(32'h600);
		rd(32'h8);
		hw_autocfg <= 1'h0;
		repeat (3) @(posedge aclk);
		wr(32'h00ff00f4);
		rd(32'h77002008);
	endtask
	task automatic print_verdict;
		if (cyc >= 4000) error_cnt++;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 4000) print_verdict;
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_map;
		t_ps;
		t_pme;
		t_dsel;
		t_auto;
		print_verdict;
	end
endmodule

// File: common/pmcap_pkg.sv
// Constants of the power management capability register bank.
//
// Summary of operation
// - Header byte 0 is a read-only capability identifier, default 01h.
// - Header byte 1 is a read-only next pointer, default 48h.
// - Version field bits 18:16 reads 011b by default, read-only.
// - PME clock bit 19 is hard-wired one, never loaded from EEPROM.
// - Device-specific-initialization bit 21 reads zero by default.
// - Auxiliary current field bits 24:22 reads zero by default.
// - D1 and D2 support bits 25 and 26 read zero, never EEPROM-loaded.
// - Bits 31:27 default to 11001b: PME forwarded in D0, D3hot, D3cold.
// - Power state bits 1:0 report and set state; 00b on, 11b D3hot.
// - Writing 01b or 10b to power state completes but changes nothing.
// - No-soft-reset bit 3 is read-only and defaults to one.
// - PME enable bit 8 gates PME, resets zero, not EEPROM-loaded.
// - Data select is EEPROM-only until an EEPROM write, then read-write.
// - Data select 0h, 3h, 4h, 7h choose the reported power reading.
// - Under hardware auto-configuration data select is read-only zero.
// - Data scale bits 14:13 show one of four loaded scales per select.
// - PME status bit 15 is set by PME, cleared by writing one.
// - Top byte shows one of four loaded data values, read-only.
// - Without an EEPROM, data and data scale read zero for every select.
package pmcap_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] HDR_OFFSET = 8'h40;
	localparam logic [7:0] CSR_OFFSET = 8'h44;
	localparam logic [7:0] CAP_ID_RST = 8'h01;
	localparam logic [7:0] NEXT_PTR_RST = 8'h48;
	localparam logic [2:0] VERSION_RST = 3'h3;
	localparam logic DSI_RST = 1'b0;
	localparam logic [2:0] AUX_RST = 3'h0;
	localparam logic [4:0] PME_SUP_RST = 5'h19;
	localparam logic [1:0] PS_D0 = 2'h0;
	localparam logic [1:0] PS_D1 = 2'h1;
	localparam logic [1:0] PS_D2 = 2'h2;
	localparam logic [1:0] PS_D3HOT = 2'h3;
	localparam logic NSR_RST = 1'b1;
	localparam logic [3:0] DS_D0_CONS = 4'h0;
	localparam logic [3:0] DS_D3_CONS = 4'h3;
	localparam logic [3:0] DS_D0_DISS = 4'h4;
	localparam logic [3:0] DS_D3_DISS = 4'h7;
	localparam int ID_LSB = 0;
	localparam int NEXT_LSB = 8;
	localparam int VER_LSB = 16;
	localparam int PMECLK_BIT = 19;
	localparam int DSI_BIT = 21;
	localparam int AUX_LSB = 22;
	localparam int D1_BIT = 25;
	localparam int D2_BIT = 26;
	localparam int SUP_LSB = 27;
	localparam int PS_LSB = 0;
	localparam int NSR_BIT = 3;
	localparam int PMEEN_BIT = 8;
	localparam int DS_LSB = 9;
	localparam int SCALE_LSB = 13;
	localparam int PMESTS_BIT = 15;
	localparam int DATA_LSB = 24;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: rtl/pmcap_regs.sv
// Power management capability registers behind an AXI4-Lite slave.
`timescale 1ns/1ps
module pmcap_regs (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic func_reset,
	// AXI4-Lite write address and data.
	input wire logic awvalid,
	output logic awready,
	input wire logic [pmcap_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response.
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read.
	input wire logic arvalid,
	output logic arready,
	input wire logic [pmcap_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Serial EEPROM loader writes.
	input wire logic ee_wr,
	input wire logic [pmcap_pkg::ADDR_W-1:0] ee_addr,
	input wire logic [31:0] ee_data,
	// Straps from pins.
	input wire logic eeprom_present,
	input wire logic hw_autocfg,
	// Power management events and status.
	input wire logic pme_event,
	output logic [1:0] power_state,
	output logic pme_enable,
	output logic pme_active
);
	import pmcap_pkg::*;

	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] ee_sync;
		logic [1:0] auto_sync;
		logic [7:0] cap_id;
		logic [7:0] next_ptr;
		logic [2:0] version;
		logic dsi;
		logic [2:0] aux;
		logic [4:0] pme_sup;
		logic [1:0] pstate;
		logic nsr;
		logic pme_en;
		logic [3:0] dsel;
		logic ds_open;
		logic pme_sts;
		logic [3:0][7:0] data;
		logic [3:0][1:0] scale;
		logic pme_act;
	} pmcap_state_t;

	pmcap_state_t s_reg;
	pmcap_state_t s_next;

	// Maps data select codes 0h, 3h, 4h, 7h onto the four loaded entries; any other code maps to 4, no entry.
	function automatic logic [2:0] sel_slot(input logic [3:0] ds);
		logic [2:0] r;
		r = 3'h4;
		if (ds == DS_D0_CONS) begin
			r = 3'h0;
		end else if (ds == DS_D3_CONS) begin
			r = 3'h1;
		end else if (ds == DS_D0_DISS) begin
			r = 3'h2;
		end else if (ds == DS_D3_DISS) begin
			r = 3'h3;
		end
		return r;
	endfunction

	// Assembles the header dword.
	function automatic logic [31:0] hdr_word(input pmcap_state_t s);
		logic [31:0] w;
		w = 32'h0;
		w[ID_LSB +: 8] = s.cap_id;
		w[NEXT_LSB +: 8] = s.next_ptr;
		w[VER_LSB +: 3] = s.version;
		w[PMECLK_BIT] = 1'b1;
		w[DSI_BIT] = s.dsi;
		w[AUX_LSB +: 3] = s.aux;
		w[D1_BIT] = 1'b0;
		w[D2_BIT] = 1'b0;
		w[SUP_LSB +: 5] = s.pme_sup;
		return w;
	endfunction

	// Assembles the status and control dword.
	function automatic logic [31:0] csr_word(input pmcap_state_t s);
		logic [31:0] w;
		logic [2:0] k;
		w = 32'h0;
		k = sel_slot(s.dsel);
		w[PS_LSB +: 2] = s.pstate;
		w[NSR_BIT] = s.nsr;
		w[PMEEN_BIT] = s.pme_en;
		w[DS_LSB +: 4] = s.auto_sync[1] ? 4'h0 : s.dsel;
		w[PMESTS_BIT] = s.pme_sts;
		if (s.ee_sync[1] && !k[2]) begin
			w[SCALE_LSB +: 2] = s.scale[k[1:0]];
			w[DATA_LSB +: 8] = s.data[k[1:0]];
		end
		return w;
	endfunction

	always_comb begin
		logic [2:0] k;
		logic [1:0] ps;
		s_next = s_reg;
		k = 3'h0;
		ps = 2'h0;
		s_next.ee_sync = {s_reg.ee_sync[0], eeprom_present};
		s_next.auto_sync = {s_reg.auto_sync[0], hw_autocfg};

		// Write address and data are taken in either order.
		if (awvalid && s_reg.awready) begin
			s_next.aw_held = 1'b1;
			s_next.aw_addr = awaddr;
		end
		if (wvalid && s_reg.wready) begin
			s_next.w_held = 1'b1;
			s_next.w_data = wdata;
			s_next.w_strb = wstrb;
		end
		if (s_reg.bvalid && bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
			s_next.aw_held = 1'b0;
			s_next.w_held = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = RESP_OKAY;
			if (s_reg.aw_addr == CSR_OFFSET) begin
				if (s_reg.w_strb[0]) begin
					ps = s_reg.w_data[PS_LSB +: 2];
					if (ps == PS_D0 || ps == PS_D3HOT) begin
						s_next.pstate = ps;
					end
				end
				if (s_reg.w_strb[1]) begin
					s_next.pme_en = s_reg.w_data[PMEEN_BIT];
					if (s_reg.ds_open && !s_reg.auto_sync[1]) begin
						s_next.dsel = s_reg.w_data[DS_LSB +: 4];
					end
					if (s_reg.w_data[PMESTS_BIT]) begin
						s_next.pme_sts = 1'b0;
					end
				end
			end else if (s_reg.aw_addr != HDR_OFFSET) begin
				s_next.bresp = RESP_SLVERR;
			end
		end

		// Loader writes to the loadable fields; PME clock, D1/D2 and PME enable stay out.
		if (ee_wr) begin
			if (ee_addr == HDR_OFFSET) begin
				s_next.cap_id = ee_data[ID_LSB +: 8];
				s_next.next_ptr = ee_data[NEXT_LSB +: 8];
				s_next.version = ee_data[VER_LSB +: 3];
				s_next.dsi = ee_data[DSI_BIT];
				s_next.aux = ee_data[AUX_LSB +: 3];
				s_next.pme_sup = ee_data[SUP_LSB +: 5];
			end else if (ee_addr == CSR_OFFSET) begin
				ps = ee_data[PS_LSB +: 2];
				if (ps == PS_D0 || ps == PS_D3HOT) begin
					s_next.pstate = ps;
				end
				s_next.nsr = ee_data[NSR_BIT];
				if (!s_reg.auto_sync[1]) begin
					s_next.dsel = ee_data[DS_LSB +: 4];
					s_next.ds_open = 1'b1;
				end
				k = sel_slot(ee_data[DS_LSB +: 4]);
				if (!k[2]) begin
					s_next.scale[k[1:0]] = ee_data[SCALE_LSB +: 2];
					s_next.data[k[1:0]] = ee_data[DATA_LSB +: 8];
				end
			end
		end

		// A PME in the clearing cycle still sets the status.
		if (pme_event && s_reg.pme_en) begin
			s_next.pme_sts = 1'b1;
		end
		s_next.pme_act = s_next.pme_sts && s_next.pme_en;

		// Reads answer one cycle after the address is taken.
		if (s_reg.rvalid && rready) begin
			s_next.rvalid = 1'b0;
		end
		if (arvalid && s_reg.arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = RESP_OKAY;
			if (araddr == HDR_OFFSET) begin
				s_next.rdata = hdr_word(s_reg);
			end else if (araddr == CSR_OFFSET) begin
				s_next.rdata = csr_word(s_reg);
			end else begin
				s_next.rdata = 32'h0;
				s_next.rresp = RESP_SLVERR;
			end
		end

		s_next.awready = !s_next.aw_held && !s_next.bvalid;
		s_next.wready = !s_next.w_held && !s_next.bvalid;
		s_next.arready = !s_next.rvalid;

		// Function reset returns power state, data select and PME status to defaults; the enable is sticky.
		if (func_reset) begin
			s_next.pstate = PS_D0;
			s_next.dsel = 4'h0;
			s_next.pme_sts = 1'b0;
			s_next.pme_act = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.awready <= 1'b1;
			s_reg.wready <= 1'b1;
			s_reg.arready <= 1'b1;
			s_reg.cap_id <= CAP_ID_RST;
			s_reg.next_ptr <= NEXT_PTR_RST;
			s_reg.version <= VERSION_RST;
			s_reg.dsi <= DSI_RST;
			s_reg.aux <= AUX_RST;
			s_reg.pme_sup <= PME_SUP_RST;
			s_reg.pstate <= PS_D0;
			s_reg.nsr <= NSR_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign awready = s_reg.awready;
	assign wready = s_reg.wready;
	assign bvalid = s_reg.bvalid;
	assign bresp = s_reg.bresp;
	assign arready = s_reg.arready;
	assign rvalid = s_reg.rvalid;
	assign rdata = s_reg.rdata;
	assign rresp = s_reg.rresp;
	assign power_state = s_reg.pstate;
	assign pme_enable = s_reg.pme_en;
	assign pme_active = s_reg.pme_act;
endmodule
